/* src/csp_map.vh */
`ifndef CSP_MAP_VH
`define CSP_MAP_VH
// Register byte offsets on the AXI4-Lite port.
`define CSP_ADDR_MODE 8'h00
`define CSP_ADDR_CLKSEL 8'h04
`define CSP_ADDR_RXBUF 8'h08
`define CSP_ADDR_RXMIRROR 8'h0C
`define CSP_ADDR_TXBUF 8'h10
`define CSP_ADDR_TXINIT 8'h14
`define CSP_ADDR_SHIFT 8'h18
// Bit positions in serial_mode_control.
`define CSP_MODE_ENABLE 7
`define CSP_MODE_DIRECTION 6
`define CSP_MODE_LENGTH 5
`define CSP_MODE_ORDER 4
`define CSP_MODE_DELAY 3
`define CSP_MODE_CONT 2
`define CSP_MODE_ACTIVE 0
`define CSP_MODE_RESET 8'h00
`define CSP_MODE_WMASK 8'hFC
`define CSP_CLKSEL_RESET 3'h0
`define CSP_SRC_TIMER 3'h6
`define CSP_SRC_SLAVE 3'h7
`define CSP_BUF_RESET 16'h0000
// Word lengths in bits.
`define CSP_BITS8 5'h08
`define CSP_BITS16 5'h10
// Clock rate and the fastest permitted serial rate.
`define CSP_SYS_HZ 50000000
`define CSP_MAX_BPS 5000000
`define CSP_MIN_HALF ((`CSP_SYS_HZ + 2 * `CSP_MAX_BPS - 1) / (2 * `CSP_MAX_BPS))
`define CSP_RESP_OKAY 2'h0
`define CSP_RESP_SLVERR 2'h2
`endif

/* src/csp_clkgen.v */
`timescale 1ns/1ps
`default_nettype none
`include "csp_map.vh"

module csp_clkgen
(
	// Clock and reset.
	input wire i_clock,
	input wire i_reset,
	// Control.
	input wire i_run,
	input wire [2:0] i_source,
	input wire i_timer_tick,
	// One pulse per serial half period.
	output reg o_half_tick
);

	localparam [31:0] MIN_HALF_W = `CSP_MIN_HALF;
	localparam [6:0] MIN_HALF = MIN_HALF_W[6:0];

	reg [6:0] cnt_r;
	wire [6:0] pow_w;
	wire [6:0] limit_w;

	assign pow_w = 7'h01 << i_source;
	// Short divisions are stretched so the line never beats 5 Mbps.
	assign limit_w = (pow_w < MIN_HALF) ? MIN_HALF : pow_w;

	always @(posedge i_clock)
	begin
		if (i_reset || !i_run)
		begin
			cnt_r <= 7'h00;
			o_half_tick <= 1'b0;
		end
		else if (i_source == `CSP_SRC_SLAVE)
		begin
			o_half_tick <= 1'b0;
		end
		else if (i_source == `CSP_SRC_TIMER)
		begin
			o_half_tick <= i_timer_tick;
		end
		else if (cnt_r == limit_w - 7'h01)
		begin
			cnt_r <= 7'h00;
			o_half_tick <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 7'h01;
			o_half_tick <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* src/csp_top.v */
// How it works
// - Serial rate from the divided system clock never exceeds five megabits per second.
// - Length bit picks 8 or 16 bit words.
// - Order bit picks MSB or LSB first.
// - Seven internal clock sources, one external slave clock.
// - Data out, data in, two-way serial clock.
// - One interrupt: transfer completed.
// - Direction bit: receive-only or transmit and receive.
// - Transmit buffer write starts transfer in transmit mode.
// - One 16-bit shift register serves both directions.
// - Only buffer accesses start transfers.
// - Mirror receive buffer returns the receive buffer content.
// - Initial buffer holds first word in continuous mode.
// - Counter counts edges, detects 8 or 16 bits.
// - Clock pin driven only with an internal clock.
// - Clearing enable resets channel circuit asynchronously.
// - Delay bit holds interrupt half serial clock with an internal clock.
// - Continuous bit picks single or continuous transfers.
// - Mode register resets to zero, status read-only.
// - Status bit reads one while transferring.
// - Receive buffer read starts reception in receive-only.
// - Mirror buffer read never starts a transfer.
`timescale 1ns/1ps
`default_nettype none
`include "csp_map.vh"

module csp_top
(
	// Clock and reset.
	input wire i_clock,
	input wire i_reset,
	// AXI4-Lite write address and data.
	input wire i_s_axi_awvalid,
	output reg o_s_axi_awready,
	input wire [7:0] i_s_axi_awaddr,
	input wire i_s_axi_wvalid,
	output reg o_s_axi_wready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	// AXI4-Lite write response.
	output reg o_s_axi_bvalid,
	input wire i_s_axi_bready,
	output reg [1:0] o_s_axi_bresp,
	// AXI4-Lite read.
	input wire i_s_axi_arvalid,
	output reg o_s_axi_arready,
	input wire [7:0] i_s_axi_araddr,
	output reg o_s_axi_rvalid,
	input wire i_s_axi_rready,
	output reg [31:0] o_s_axi_rdata,
	output reg [1:0] o_s_axi_rresp,
	// Serial link.
	input wire i_serial_in_pin,
	input wire i_serial_clock_pin,
	output reg o_serial_clock_pin,
	output reg o_serial_clock_oe,
	output reg o_serial_out_pin,
	// Timer-made serial clock, one pulse per half period.
	input wire i_timer_tick,
	// Completion event.
	output reg o_transfer_done_irq
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_RUN = 2'h1;
	localparam [1:0] ST_DELAY = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Bit helpers.

	function f_outbit;
		input [15:0] sh;
		input len16;
		input lsb;
		begin
			if (lsb)
				f_outbit = sh[0];
			else if (len16)
				f_outbit = sh[15];
			else
				f_outbit = sh[7];
		end
	endfunction

	function [15:0] f_shin;
		input [15:0] sh;
		input din;
		input len16;
		input lsb;
		begin
			if (!lsb && len16)
				f_shin = {sh[14:0], din};
			else if (!lsb)
				// Byte mode keeps the upper half clear in both orders.
				f_shin = {8'h00, sh[6:0], din};
			else if (len16)
				f_shin = {din, sh[15:1]};
			else
				f_shin = {8'h00, din, sh[7:1]};
		end
	endfunction

	function [15:0] f_lanes;
		input [15:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			f_lanes = old;
			if (strb[0])
				f_lanes[7:0] = data[7:0];
			if (strb[1])
				f_lanes[15:8] = data[15:8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Software-visible state.

	reg [7:0] mode_r;
	reg [2:0] src_r;
	reg [15:0] txbuf_r;
	reg [15:0] initbuf_r;
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg start_r;
	reg core_clr_r;
	reg [31:0] rd_data;
	reg rd_err;

	// Core state, cleared with the channel.
	reg [1:0] state_r;
	reg [4:0] cnt_r;
	reg [15:0] shift_r;
	reg [15:0] rxbuf_r;
	reg active_r;
	reg pend_r;

	// Pin synchronisers.
	reg sck_s1_r;
	reg sck_s2_r;
	reg sck_s3_r;
	reg sin_s1_r;
	reg sin_s2_r;

	wire master_w;
	wire len16_w;
	wire lsb_w;
	wire txmode_w;
	wire cont_w;
	wire [4:0] len_w;
	wire half_tick_w;
	wire fall_w;
	wire rise_w;
	wire [15:0] shin_w;
	wire [15:0] load_w;

	assign master_w = (src_r != `CSP_SRC_SLAVE);
	assign len16_w = mode_r[`CSP_MODE_LENGTH];
	assign lsb_w = mode_r[`CSP_MODE_ORDER];
	assign txmode_w = mode_r[`CSP_MODE_DIRECTION];
	assign cont_w = mode_r[`CSP_MODE_CONT];
	assign len_w = len16_w ? `CSP_BITS16 : `CSP_BITS8;

	////////////////////////////////////////////////////////////////////////
	// Register read decode.

	always @*
	begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		case (i_s_axi_araddr)
			`CSP_ADDR_MODE:
				rd_data[7:0] = {mode_r[7:1], active_r};
			`CSP_ADDR_CLKSEL:
				rd_data[2:0] = src_r;
			`CSP_ADDR_RXBUF:
				rd_data[15:0] = rxbuf_r;
			`CSP_ADDR_RXMIRROR:
				rd_data[15:0] = rxbuf_r;
			`CSP_ADDR_TXBUF:
				rd_data[15:0] = txbuf_r;
			`CSP_ADDR_TXINIT:
				rd_data[15:0] = initbuf_r;
			`CSP_ADDR_SHIFT:
				rd_data[15:0] = shift_r;
			default:
				rd_err = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave and register writes.

	always @(posedge i_clock)
	begin
		if (i_reset)
		begin
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready <= 1'b1;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= `CSP_RESP_OKAY;
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
			o_s_axi_rresp <= `CSP_RESP_OKAY;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			mode_r <= `CSP_MODE_RESET;
			src_r <= `CSP_CLKSEL_RESET;
			txbuf_r <= `CSP_BUF_RESET;
			initbuf_r <= `CSP_BUF_RESET;
			start_r <= 1'b0;
			core_clr_r <= 1'b1;
			o_serial_clock_oe <= 1'b0;
		end
		else
		begin
			start_r <= 1'b0;
			core_clr_r <= ~mode_r[`CSP_MODE_ENABLE];
			o_serial_clock_oe <= mode_r[`CSP_MODE_ENABLE] & master_w;
			if (i_s_axi_awvalid && o_s_axi_awready)
			begin
				awaddr_r <= i_s_axi_awaddr;
				o_s_axi_awready <= 1'b0;
			end
			if (i_s_axi_wvalid && o_s_axi_wready)
			begin
				wdata_r <= i_s_axi_wdata;
				wstrb_r <= i_s_axi_wstrb;
				o_s_axi_wready <= 1'b0;
			end
			if (!o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid)
			begin
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= `CSP_RESP_OKAY;
				case (awaddr_r)
					`CSP_ADDR_MODE:
						if (wstrb_r[0])
							mode_r <= wdata_r[7:0] & `CSP_MODE_WMASK;
					`CSP_ADDR_CLKSEL:
						// The source may only change with the channel off.
						if (wstrb_r[0] && !mode_r[`CSP_MODE_ENABLE])
							src_r <= wdata_r[2:0];
					`CSP_ADDR_TXBUF:
					begin
						txbuf_r <= f_lanes(txbuf_r, wdata_r, wstrb_r);
						start_r <= txmode_w;
					end
					`CSP_ADDR_TXINIT:
						initbuf_r <= f_lanes(initbuf_r, wdata_r, wstrb_r);
					`CSP_ADDR_RXBUF,
					`CSP_ADDR_RXMIRROR,
					`CSP_ADDR_SHIFT:
						o_s_axi_bresp <= `CSP_RESP_OKAY;
					default:
						o_s_axi_bresp <= `CSP_RESP_SLVERR;
				endcase
			end
			if (o_s_axi_bvalid && i_s_axi_bready)
			begin
				o_s_axi_bvalid <= 1'b0;
				o_s_axi_awready <= 1'b1;
				o_s_axi_wready <= 1'b1;
			end
			if (i_s_axi_arvalid && o_s_axi_arready)
			begin
				o_s_axi_arready <= 1'b0;
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rdata <= rd_data;
				o_s_axi_rresp <= rd_err ? `CSP_RESP_SLVERR : `CSP_RESP_OKAY;
				// Only the main receive buffer triggers; the mirror does not.
				if (i_s_axi_araddr == `CSP_ADDR_RXBUF && !txmode_w)
					start_r <= 1'b1;
			end
			if (o_s_axi_rvalid && i_s_axi_rready)
			begin
				o_s_axi_rvalid <= 1'b0;
				o_s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial clock selection and edge finding.

	always @(posedge i_clock)
	begin
		if (i_reset)
		begin
			sck_s1_r <= 1'b1;
			sck_s2_r <= 1'b1;
			sck_s3_r <= 1'b1;
			sin_s1_r <= 1'b0;
			sin_s2_r <= 1'b0;
		end
		else
		begin
			sck_s1_r <= i_serial_clock_pin;
			sck_s2_r <= sck_s1_r;
			sck_s3_r <= sck_s2_r;
			sin_s1_r <= i_serial_in_pin;
			sin_s2_r <= sin_s1_r;
		end
	end

	csp_clkgen u_clkgen
	(
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_run(master_w && state_r != ST_IDLE),
		.i_source(src_r),
		.i_timer_tick(i_timer_tick),
		.o_half_tick(half_tick_w)
	);

	// Idle-high clock: data changes on the falling edge, is sampled on
	// the rising one.
	assign fall_w = master_w ? (half_tick_w & o_serial_clock_pin)
		: (sck_s3_r & ~sck_s2_r);
	assign rise_w = master_w ? (half_tick_w & ~o_serial_clock_pin)
		: (~sck_s3_r & sck_s2_r);
	assign shin_w = f_shin(shift_r, sin_s2_r, len16_w, lsb_w);
	assign load_w = cont_w ? initbuf_r : txbuf_r;

	////////////////////////////////////////////////////////////////////////
	// Transfer engine. A cleared enable bit clears it without the clock.

	always @(posedge i_clock or posedge core_clr_r)
	begin
		if (core_clr_r)
		begin
			state_r <= ST_IDLE;
			cnt_r <= 5'h00;
			shift_r <= `CSP_BUF_RESET;
			rxbuf_r <= `CSP_BUF_RESET;
			active_r <= 1'b0;
			pend_r <= 1'b0;
			o_serial_clock_pin <= 1'b1;
			o_serial_out_pin <= 1'b0;
			o_transfer_done_irq <= 1'b0;
		end
		else
		begin
			o_transfer_done_irq <= 1'b0;
			case (state_r)
				ST_IDLE:
					if (start_r)
					begin
						state_r <= ST_RUN;
						active_r <= 1'b1;
						cnt_r <= 5'h00;
						// In continuous transmit the buffer already holds word two.
						pend_r <= cont_w & txmode_w;
						if (txmode_w)
							shift_r <= load_w;
						o_serial_out_pin <= txmode_w &
							f_outbit(load_w, len16_w, lsb_w);
					end
				ST_RUN:
				begin
					if (fall_w)
					begin
						// As slave the clock output is not driven and idles high.
						if (master_w)
							o_serial_clock_pin <= 1'b0;
						o_serial_out_pin <= txmode_w &
							f_outbit(shift_r, len16_w, lsb_w);
					end
					if (rise_w)
					begin
						if (master_w)
							o_serial_clock_pin <= 1'b1;
						shift_r <= shin_w;
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r + 5'h01 == len_w)
						begin
							rxbuf_r <= shin_w;
							cnt_r <= 5'h00;
							if (cont_w && pend_r)
							begin
								// Next word follows without a gap.
								pend_r <= 1'b0;
								o_transfer_done_irq <= 1'b1;
								if (txmode_w)
									shift_r <= txbuf_r;
							end
							else
							begin
								active_r <= 1'b0;
								if (mode_r[`CSP_MODE_DELAY] && master_w)
									state_r <= ST_DELAY;
								else
								begin
									state_r <= ST_IDLE;
									o_transfer_done_irq <= 1'b1;
								end
							end
						end
					end
					// A trigger in the same cycle as the word end counts only when a word was already pending.
					if (start_r && cont_w)
						pend_r <= 1'b1;
				end
				ST_DELAY:
					if (half_tick_w)
					begin
						state_r <= ST_IDLE;
						o_transfer_done_irq <= 1'b1;
					end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

/* sim/csp_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module csp_top_properties
(
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_reset,
	// Register bus.
	input wire logic i_s_axi_awvalid,
	input wire logic o_s_axi_awready,
	input wire logic i_s_axi_wvalid,
	input wire logic o_s_axi_wready,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [1:0] o_s_axi_bresp,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic [31:0] o_s_axi_rdata,
	// Serial link.
	input wire logic o_serial_clock_pin,
	input wire logic o_serial_clock_oe,
	input wire logic o_transfer_done_irq
);
default clocking cb @(posedge i_clock);
endclocking
default disable iff (i_reset);
logic prev_r;
logic [4:0] rises_r;
logic [4:0] total;
// A rise in the same cycle as the pulse still belongs to that word.
assign total = rises_r + {4'h0, o_serial_clock_pin & ~prev_r};
always @(posedge i_clock)
begin
	prev_r <= o_serial_clock_pin;
	if (i_reset || !o_serial_clock_oe || o_transfer_done_irq)
		rises_r <= 5'h00;
	else
		rises_r <= total;
end
////////////////////////////////////////
a_irq_one_cycle:
assert property (o_transfer_done_irq |=> !o_transfer_done_irq)
	else $error("completion pulse too long");
a_word_bit_count:
assert property (o_serial_clock_oe && o_transfer_done_irq
	|-> total == 5'h08 || total == 5'h10) else $error("bad bit count");
a_clock_low_min:
assert property (disable iff (i_reset || !o_serial_clock_oe)
	$fell(o_serial_clock_pin) |-> !o_serial_clock_pin [*5])
	else $error("serial clock low too short");
a_clock_high_min:
assert property (disable iff (i_reset || !o_serial_clock_oe)
	$rose(o_serial_clock_pin) |-> o_serial_clock_pin [*5])
	else $error("serial clock high too short");
a_clock_idle_high:
assert property (!o_serial_clock_oe |-> o_serial_clock_pin)
	else $error("undriven clock output not high");
a_write_answer:
assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
	&& o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid)
	else $error("no write response");
a_read_answer:
assert property (i_s_axi_arvalid && o_s_axi_arready |-> ##[1:2] o_s_axi_rvalid)
	else $error("no read response");
a_bresp_hold:
assert property (o_s_axi_bvalid && !i_s_axi_bready
	|=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("bresp dropped");
a_rdata_hold:
assert property (o_s_axi_rvalid && !i_s_axi_rready
	|=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rdata dropped");
a_reset_quiet:
assert property (disable iff (1'b0) i_reset |=> !o_transfer_done_irq
	&& !o_s_axi_bvalid && !o_serial_clock_oe && o_serial_clock_pin)
	else $error("outputs busy in reset");
endmodule
bind csp_top csp_top_properties csp_top_properties_i (.*);
`default_nettype wire

/* sim/csp_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module csp_peer
(
	// Link wires.
	input wire logic i_sck,
	input wire logic i_sdo,
	input wire logic i_live,
	// Word format and word to send.
	input wire logic i_len16,
	input wire logic i_lsb,
	input wire logic [15:0] i_word,
	// Data to the device and the last two words heard.
	output logic o_sdi,
	output logic [15:0] o_rx,
	output logic [15:0] o_prev
);
int n = 0;
logic [15:0] sh;
function automatic int pos(input int k);
	pos = i_lsb ? k : (i_len16 ? 15 : 7) - k;
endfunction
logic sdi_r = 1'b0;
assign o_sdi = sdi_r;
// Bits change on the fall so they are settled at the sampling rise.
always @(posedge i_sck or negedge i_sck)
	if (i_live && !i_sck)
		sdi_r <= i_word[pos(n)];
	else if (i_live)
	begin
		sh[pos(n)] = i_sdo;
		n = n + 1;
		if (n == (i_len16 ? 16 : 8))
		begin
			n = 0;
			o_prev <= o_rx;
			o_rx <= sh;
			// No data between words, so the line shows the inverse. It
			// turns late: a slave sampler sees the rise through a synchroniser.
			sdi_r <= #60 ~sdi_r;
		end
	end
endmodule
`default_nettype wire

/* sim/csp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csp_map.vh"
module csp_top_tb;
logic clk = 1'b0;
logic rst = 1'b1;
logic awv = 1'b0;
logic wv = 1'b0;
logic bre = 1'b0;
logic arv = 1'b0;
logic rre = 1'b0;
logic tick = 1'b0;
logic ext_sck = 1'b1;
logic len16 = 1'b0;
logic lsb = 1'b0;
logic sck_d = 1'b1;
logic [3:0] ws = 4'hF;
logic [7:0] awa = 8'h00;
logic [7:0] ara = 8'h00;
logic [31:0] wd = 32'h0;
logic [15:0] pw = 16'h0;
wire awr, wrd, bv, arr, rv, sck, oe, sdo, irq, sdi;
wire [1:0] br;
wire [1:0] rr;
wire [31:0] rdat;
wire [15:0] prx;
wire [15:0] pprev;
// The clock line has a pull-up, so an undriven line reads high.
wire sck_w = oe ? sck : ext_sck;
integer seed = 32'h8317;
int bad_count = 0;
int num_checks = 0;
int cyc = 0;
int irq_n = 0;
int rise = 0;
int lat_r = 0;
int lat[8];
always #10 clk = ~clk;
csp_top csp_top_i
(
	.i_clock(clk), .i_reset(rst), .i_s_axi_awvalid(awv),
	.o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv),
	.o_s_axi_wready(wrd), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
	.o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .o_s_axi_bresp(br),
	.i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
	.o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rdat),
	.o_s_axi_rresp(rr), .i_serial_in_pin(sdi), .i_serial_clock_pin(sck_w),
	.o_serial_clock_pin(sck), .o_serial_clock_oe(oe), .o_serial_out_pin(sdo),
	.i_timer_tick(tick), .o_transfer_done_irq(irq)
);
csp_peer csp_peer_i
(
	.i_sck(sck_w), .i_sdo(sdo), .i_live(!rst), .i_len16(len16), .i_lsb(lsb),
	.i_word(pw), .o_sdi(sdi), .o_rx(prx), .o_prev(pprev)
);
////////////////////////////////////////
task automatic report_and_stop();
	$display("checks %0d, mismatches %0d", num_checks, bad_count);
	if (bad_count == 0 && num_checks > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
task automatic chk(input logic [31:0] g, input logic [31:0] e);
	num_checks++;
	if (g !== e)
	begin
		bad_count++;
		$display("unexpected at %0t: got %h, expected %h", $time, g, e);
	end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d,
	input logic [1:0] e);
	bit got;
	got = 0;
	awa <= a;
	wd <= d;
	awv <= 1'b1;
	wv <= 1'b1;
	bre <= 1'b1;
	while (!got)
	begin
		@(posedge clk);
		if (awr)
			awv <= 1'b0;
		if (wrd)
			wv <= 1'b0;
		if (bv)
		begin
			got = 1;
			bre <= 1'b0;
			chk({30'h0, br}, {30'h0, e});
		end
	end
	@(posedge clk);
endtask
task automatic rd(input logic [7:0] a, input logic [1:0] e,
	output logic [31:0] d);
	bit got;
	got = 0;
	ara <= a;
	arv <= 1'b1;
	rre <= 1'b1;
	while (!got)
	begin
		@(posedge clk);
		if (arr)
			arv <= 1'b0;
		if (rv)
		begin
			got = 1;
			rre <= 1'b0;
			d = rdat;
			chk({30'h0, rr}, {30'h0, e});
		end
	end
	@(posedge clk);
endtask
task automatic cfg(input logic [7:0] m, input logic [2:0] s);
	wr(`CSP_ADDR_MODE, 32'h0, 2'h0);
	wr(`CSP_ADDR_CLKSEL, {29'h0, s}, 2'h0);
	wr(`CSP_ADDR_MODE, {24'h0, m}, 2'h0);
endtask
task automatic wirq(input int t);
	while (irq_n < t)
		@(posedge clk);
endtask
function automatic logic [31:0] msk(input logic l);
	msk = l ? 32'h0000FFFF : 32'h000000FF;
endfunction
always @(posedge clk)
begin
	cyc <= cyc + 1;
	tick <= cyc[2:0] == 3'h0;
	sck_d <= sck;
	if (oe && sck && !sck_d)
		rise <= cyc;
	if (irq)
	begin
		irq_n <= irq_n + 1;
		// A rise seen at this same edge is newer than the stored one.
		lat_r <= (oe && sck && !sck_d) ? 0 : cyc - rise;
	end
	if (cyc == 30000)
	begin
		bad_count++;
		report_and_stop();
	end
end
initial
begin
	int k;
	int n0;
	logic [31:0] d;
	logic [31:0] q;
	logic [31:0] m;
	repeat (10) @(posedge clk);
	rst <= 1'b0;
	@(posedge clk);
	for (k = 0; k < 28; k = k + 4)
	begin
		rd(k[7:0], 2'h0, q);
		chk(q, 32'h0);
	end
	wr(`CSP_ADDR_MODE, 32'h7F, 2'h0);
	rd(`CSP_ADDR_MODE, 2'h0, q);
	chk(q, 32'h7C);
	wr(8'h1C, 32'h1, `CSP_RESP_SLVERR);
	rd(8'h1C, `CSP_RESP_SLVERR, q);
	chk(q, 32'h0);
	wr(`CSP_ADDR_TXINIT, 32'hABCD, 2'h0);
	ws <= 4'h1;
	wr(`CSP_ADDR_TXINIT, 32'h1234, 2'h0);
	ws <= 4'hF;
	rd(`CSP_ADDR_TXINIT, 2'h0, q);
	chk(q, 32'hAB34);
	$display("test registers done at %0t", $time);
	for (k = 0; k < 8; k = k + 1)
	begin
		m = {24'h0, 2'b11, k[0], k[1], k[2], 3'h0};
		len16 <= k[0];
		lsb <= k[1];
		cfg(m[7:0], k[0] ? `CSP_SRC_TIMER : 3'h3);
		d = $random(seed);
		pw <= 16'($random(seed));
		n0 = irq_n;
		wr(`CSP_ADDR_TXBUF, d, 2'h0);
		repeat (2) @(posedge clk);
		rd(`CSP_ADDR_MODE, 2'h0, q);
		chk(q, m | 32'h1);
		wirq(n0 + 1);
		lat[k] = lat_r;
		chk(prx & msk(k[0]), d & msk(k[0]));
		rd(`CSP_ADDR_RXBUF, 2'h0, q);
		chk(q, pw & msk(k[0]));
		rd(`CSP_ADDR_RXMIRROR, 2'h0, q);
		chk(q, pw & msk(k[0]));
		rd(`CSP_ADDR_MODE, 2'h0, q);
		chk(q, m);
	end
	for (k = 0; k < 4; k = k + 1)
		chk(lat[k + 4] - lat[k], 32'h8);
	$display("test transfers done at %0t", $time);
	len16 <= 1'b0;
	lsb <= 1'b0;
	cfg(8'h80, 3'h3);
	pw <= 16'($random(seed));
	n0 = irq_n;
	rd(`CSP_ADDR_RXBUF, 2'h0, q);
	wirq(n0 + 1);
	chk(prx & 32'hFF, 32'h0);
	rd(`CSP_ADDR_RXMIRROR, 2'h0, q);
	chk(q, pw & 32'hFF);
	repeat (40) @(posedge clk);
	rd(`CSP_ADDR_MODE, 2'h0, q);
	chk(q, 32'h80);
	cfg(8'hC4, 3'h3);
	d = $random(seed);
	n0 = irq_n;
	wr(`CSP_ADDR_TXINIT, {24'h0, d[15:8]}, 2'h0);
	wr(`CSP_ADDR_TXBUF, {24'h0, d[7:0]}, 2'h0);
	wirq(n0 + 2);
	chk(pprev & 32'hFF, {24'h0, d[15:8]});
	chk(prx & 32'hFF, {24'h0, d[7:0]});
	len16 <= 1'b1;
	cfg(8'hE0, `CSP_SRC_SLAVE);
	pw <= 16'($random(seed));
	n0 = irq_n;
	wr(`CSP_ADDR_TXBUF, d, 2'h0);
	repeat (4) @(posedge clk);
	#5;
	repeat (16)
	begin
		ext_sck = 1'b0;
		#80 ext_sck = 1'b1;
		#80;
	end
	wirq(n0 + 1);
	chk({31'h0, oe}, 32'h0);
	chk(prx, d & 32'hFFFF);
	rd(`CSP_ADDR_RXBUF, 2'h0, q);
	chk(q, pw);
	cfg(8'hE0, 3'h0);
	n0 = irq_n;
	wr(`CSP_ADDR_TXBUF, d, 2'h0);
	repeat (30) @(posedge clk);
	wr(`CSP_ADDR_MODE, 32'h60, 2'h0);
	repeat (3) @(posedge clk);
	rd(`CSP_ADDR_SHIFT, 2'h0, q);
	chk(q, 32'h0);
	rd(`CSP_ADDR_MODE, 2'h0, q);
	chk(q, 32'h60);
	chk(irq_n, n0);
	$display("test link done at %0t", $time);
	report_and_stop();
end
endmodule
`default_nettype wire
